// [fbse_pkg.sv]
// package of the fieldbus state error handler: states, request codes, error codes
// assumes one clock domain; the master's requests arrive synchronous to it
package fbse_pkg;

    // =====================================================================
    // slave state machine states, gray coded along init-preop-safeop-op
    typedef enum logic [2:0] {
        ST_INIT   = 3'h0,
        ST_PREOP  = 3'h1,
        ST_SAFEOP = 3'h3,
        ST_OP     = 3'h2,
        ST_BOOT   = 3'h4
    } fbse_state_t;

    localparam fbse_state_t STATE_RESET = ST_INIT;

    // =====================================================================
    // state codes carried by a transition request
    localparam logic [3:0] REQ_INIT = 4'h1;
    localparam logic [3:0] REQ_PREOP = 4'h2;
    localparam logic [3:0] REQ_BOOT = 4'h3;
    localparam logic [3:0] REQ_SAFEOP = 4'h4;
    localparam logic [3:0] REQ_OP = 4'h8;

    // =====================================================================
    // error codes
    localparam logic [7:0] MAIN_COMM = 8'h80;
    localparam logic [7:0] MAIN_SM = 8'h81;
    localparam logic [3:0] SUB_MEM_RANGE = 4'h3;
    localparam logic [3:0] SUB_FW_WRITE = 4'h5;
    localparam logic [3:0] SUB_DESC_MISMATCH = 4'h6;
    localparam logic [3:0] SUB_ILLEGAL_TR = 4'h1;
    localparam logic [3:0] SUB_UNKNOWN_TR = 4'h2;
    localparam logic [3:0] SUB_BOOT_UNSUP = 4'h3;
    localparam logic [3:0] SUB_FW_INCOMPAT = 4'h4;
    localparam logic [3:0] SUB_MBX_BOOT = 4'h5;
    localparam logic [7:0] MAIN_RESET = 8'h00;
    localparam logic [3:0] SUB_RESET = 4'h0;

    // highest memory address that the master may reach
    localparam logic [15:0] MEM_ADDR_LIMIT = 16'h0fff;

    // =====================================================================
    // front display characters (ascii)
    localparam logic [7:0] CHR_E = 8'h45;
    localparam logic [7:0] CHR_R = 8'h72;
    localparam logic [7:0] CHR_BLANK = 8'h20;
    localparam logic [7:0] CHR_DIGIT0 = 8'h30;
    localparam logic [7:0] CHR_LETTER_A = 8'h61;
    localparam logic [39:0] DISP_RESET = {5{8'h20}};

endpackage

// [fbse_err_if.sv]
// carrier of one error report from the detector to the code latch
// assumes both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none

interface fbse_err_if;
    logic evt;
    logic [7:0] main_code;
    logic [3:0] sub_code;

    modport src (output evt, output main_code, output sub_code);
    modport sink (input evt, input main_code, input sub_code);
endinterface

`default_nettype wire

// [fbse_err_latch.sv]
// latch of the most recent error code and its front display text
// assumes the report pulse lasts one cycle; clear is a level or pulse
`timescale 1ns/1ps
`default_nettype none

module fbse_err_latch
    import fbse_pkg::*;
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    fbse_err_if.sink err,
    input wire logic clear_in,
    output logic active_out,
    output logic [7:0] main_out,
    output logic [3:0] sub_out,
    output logic [39:0] disp_out
);
    import fbse_pkg::*;

    // =====================================================================
    // code to character
    function automatic logic [7:0] hex_chr(input logic [3:0] d);
        if (d < 4'ha) begin
            hex_chr = CHR_DIGIT0 + {4'h0, d};
        end else begin
            hex_chr = CHR_LETTER_A + {4'h0, d - 4'ha};
        end
    endfunction

    logic active_reg;
    logic [7:0] main_reg;
    logic [3:0] sub_reg;
    logic [39:0] disp_reg;
    logic active_next;
    logic [39:0] disp_next;

    // a new report wins over a clear in the same cycle
    assign active_next = err.evt | (active_reg & ~clear_in);
    assign disp_next = err.evt ? {CHR_E, CHR_R, hex_chr(err.main_code[7:4]),
                                  hex_chr(err.main_code[3:0]), hex_chr(err.sub_code)}
                     : (active_next ? disp_reg : DISP_RESET);

    // =====================================================================
    // storage
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            active_reg <= 1'b0;
            main_reg <= MAIN_RESET;
            sub_reg <= SUB_RESET;
            disp_reg <= DISP_RESET;
        end else begin
            active_reg <= active_next;
            main_reg <= err.evt ? err.main_code : main_reg;
            sub_reg <= err.evt ? err.sub_code : sub_reg;
            disp_reg <= disp_next;
        end
    end

    assign active_out = active_reg;
    assign main_out = main_reg;
    assign sub_out = sub_reg;
    assign disp_out = disp_reg;

    // =====================================================================
    // checks
    property p_disp_code;
        @(posedge clk_in) disable iff (!arst_n_in)
        err.evt |=> active_reg && disp_reg[39:24] == {CHR_E, CHR_R}
            && disp_reg[7:0] == hex_chr($past(err.sub_code));
    endproperty
    a_disp_code: assert property (p_disp_code) else $error("display lost the code");

    property p_clear;
        @(posedge clk_in) disable iff (!arst_n_in)
        clear_in && !err.evt |=> !active_reg && disp_reg == DISP_RESET;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not blank the display");

endmodule

`default_nettype wire

// [fbse_handler.sv]
// fieldbus slave state machine with its error detection and reporting
// assumes the master's request, memory access and fault inputs are synchronous
//
// Operation
// - memory access beyond the limit reports 80/3, state kept.
// - firmware write failure in boot reports 80/5, state kept.
// - description file mismatch in init reports 80/6, state kept.
// - illegal transition reports 81/1; operational falls to safe-operational.
// - request for a nonexistent state reports 81/2; operational falls to safe-operational.
// - unsupported init-to-boot request reports 81/3, state stays init.
// - incompatible firmware in boot or init reports 81/4, state kept.
// - mailbox unfit for boot during init-to-boot reports 81/5, ends in init.
`timescale 1ns/1ps
`default_nettype none

module fbse_handler
    import fbse_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic ARST_N_IN,
    input wire logic REQ_VALID_IN,
    input wire logic [3:0] REQ_STATE_IN,
    input wire logic MEM_REQ_IN,
    input wire logic [15:0] MEM_ADDR_IN,
    input wire logic FW_WRITE_FAIL_IN,
    input wire logic DESC_MISMATCH_IN,
    input wire logic FW_INCOMPAT_IN,
    input wire logic BOOT_SUPPORTED_IN,
    input wire logic MBX_BOOT_OK_IN,
    input wire logic ERR_CLEAR_IN,
    output logic [2:0] STATE_OUT,
    output logic ERR_EVENT_OUT,
    output logic ERR_ACTIVE_OUT,
    output logic [7:0] ERR_MAIN_OUT,
    output logic [3:0] ERR_SUB_OUT,
    output logic [39:0] DISP_OUT
);
    import fbse_pkg::*;

    // =====================================================================
    // request decoding
    function automatic fbse_state_t code_to_state(input logic [3:0] c);
        case (c)
            REQ_PREOP: code_to_state = ST_PREOP;
            REQ_BOOT: code_to_state = ST_BOOT;
            REQ_SAFEOP: code_to_state = ST_SAFEOP;
            REQ_OP: code_to_state = ST_OP;
            default: code_to_state = ST_INIT;
        endcase
    endfunction

    // transitions other than init to boot, which has checks of its own
    function automatic logic legal_step(input fbse_state_t from, input fbse_state_t to);
        case (from)
            ST_INIT: legal_step = (to == ST_PREOP);
            ST_PREOP: legal_step = (to == ST_INIT) || (to == ST_SAFEOP);
            ST_SAFEOP: legal_step = (to == ST_INIT) || (to == ST_PREOP) || (to == ST_OP);
            ST_OP: legal_step = (to == ST_INIT) || (to == ST_PREOP) || (to == ST_SAFEOP);
            default: legal_step = (to == ST_INIT);
        endcase
    endfunction

    fbse_state_t state_reg;
    fbse_state_t state_next;
    fbse_state_t req_st;
    logic err_event_reg;

    wire req_known = (REQ_STATE_IN == REQ_INIT) || (REQ_STATE_IN == REQ_PREOP)
                  || (REQ_STATE_IN == REQ_BOOT) || (REQ_STATE_IN == REQ_SAFEOP)
                  || (REQ_STATE_IN == REQ_OP);
    assign req_st = code_to_state(REQ_STATE_IN);
    wire req_ok = REQ_VALID_IN && req_known;
    wire req_same = req_ok && (req_st == state_reg);
    wire req_boot = req_ok && (state_reg == ST_INIT) && (req_st == ST_BOOT);

    // =====================================================================
    // fault detection, each limited to the states where it applies
    wire err_unknown = REQ_VALID_IN && !req_known;
    wire err_illegal = req_ok && !req_same && !req_boot
                    && !legal_step(state_reg, req_st);
    wire err_boot_unsup = req_boot && !BOOT_SUPPORTED_IN;
    wire err_mbx = req_boot && BOOT_SUPPORTED_IN && !MBX_BOOT_OK_IN;
    wire err_fw_incompat = FW_INCOMPAT_IN
                        && ((state_reg == ST_INIT) || (state_reg == ST_BOOT));
    wire err_desc = DESC_MISMATCH_IN && (state_reg == ST_INIT);
    wire err_fw_write = FW_WRITE_FAIL_IN && (state_reg == ST_BOOT);
    wire err_mem = MEM_REQ_IN && (MEM_ADDR_IN > MEM_ADDR_LIMIT);
    wire err_any = err_unknown || err_illegal || err_boot_unsup || err_mbx
                || err_fw_incompat || err_desc || err_fw_write || err_mem;

    // one code per cycle: transition faults first, then firmware and description faults, then memory
    wire [3:0] sub_sel = err_unknown ? SUB_UNKNOWN_TR
                       : err_illegal ? SUB_ILLEGAL_TR
                       : err_boot_unsup ? SUB_BOOT_UNSUP
                       : err_mbx ? SUB_MBX_BOOT
                       : err_fw_incompat ? SUB_FW_INCOMPAT
                       : err_desc ? SUB_DESC_MISMATCH
                       : err_fw_write ? SUB_FW_WRITE
                       : SUB_MEM_RANGE;
    wire main_is_sm = err_unknown || err_illegal || err_boot_unsup || err_mbx
                   || err_fw_incompat;

    // =====================================================================
    // next state: a bad request keeps lower states and drops op to safeop
    wire fall_back = (err_unknown || err_illegal) && (state_reg == ST_OP);
    wire step_ok = req_ok && !req_same
                && (req_boot ? (BOOT_SUPPORTED_IN && MBX_BOOT_OK_IN)
                             : legal_step(state_reg, req_st));

    always_comb begin
        state_next = state_reg;
        if (fall_back) begin
            state_next = ST_SAFEOP;
        end else if (step_ok) begin
            state_next = req_st;
        end
    end

    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            state_reg <= STATE_RESET;
            err_event_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            err_event_reg <= err_any;
        end
    end

    // =====================================================================
    // error code latch and display
    fbse_err_if err_bus ();
    assign err_bus.evt = err_any;
    assign err_bus.main_code = main_is_sm ? MAIN_SM : MAIN_COMM;
    assign err_bus.sub_code = sub_sel;

    fbse_err_latch u_fbse_err_latch (
        .clk_in(MCLK_IN),
        .arst_n_in(ARST_N_IN),
        .err(err_bus.sink),
        .clear_in(ERR_CLEAR_IN),
        .active_out(ERR_ACTIVE_OUT),
        .main_out(ERR_MAIN_OUT),
        .sub_out(ERR_SUB_OUT),
        .disp_out(DISP_OUT)
    );

    assign STATE_OUT = state_reg;
    assign ERR_EVENT_OUT = err_event_reg;

    // =====================================================================
    // checks
    property p_mem;
        @(posedge MCLK_IN) disable iff (!ARST_N_IN)
        MEM_REQ_IN && MEM_ADDR_IN > MEM_ADDR_LIMIT && !REQ_VALID_IN && !FW_INCOMPAT_IN
            && !DESC_MISMATCH_IN && !FW_WRITE_FAIL_IN
        |=> ERR_MAIN_OUT == 8'h80 && ERR_SUB_OUT == 4'h3 && $stable(STATE_OUT);
    endproperty
    a_mem: assert property (p_mem) else $error("memory range fault misreported");

    property p_fw_write;
        @(posedge MCLK_IN) disable iff (!ARST_N_IN)
        state_reg == ST_BOOT && FW_WRITE_FAIL_IN && !REQ_VALID_IN && !FW_INCOMPAT_IN
        |=> ERR_MAIN_OUT == 8'h80 && ERR_SUB_OUT == 4'h5 && state_reg == ST_BOOT;
    endproperty
    a_fw_write: assert property (p_fw_write)
        else $error("firmware write fault misreported");

    property p_desc;
        @(posedge MCLK_IN) disable iff (!ARST_N_IN)
        state_reg == ST_INIT && DESC_MISMATCH_IN && !REQ_VALID_IN && !FW_INCOMPAT_IN
        |=> ERR_MAIN_OUT == 8'h80 && ERR_SUB_OUT == 4'h6 && state_reg == ST_INIT
            && ERR_EVENT_OUT;
    endproperty
    a_desc: assert property (p_desc) else $error("description mismatch misreported");

    property p_illegal_op;
        @(posedge MCLK_IN) disable iff (!ARST_N_IN)
        state_reg == ST_OP && REQ_VALID_IN && REQ_STATE_IN == REQ_BOOT
        |=> state_reg == ST_SAFEOP && ERR_MAIN_OUT == 8'h81 && ERR_SUB_OUT == 4'h1;
    endproperty
    a_illegal_op: assert property (p_illegal_op)
        else $error("illegal request from op wrong");

    property p_unknown;
        @(posedge MCLK_IN) disable iff (!ARST_N_IN)
        state_reg != ST_OP && REQ_VALID_IN && !req_known
        |=> $stable(state_reg) && ERR_MAIN_OUT == 8'h81 && ERR_SUB_OUT == 4'h2;
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown request handled wrong");

    property p_boot_unsup;
        @(posedge MCLK_IN) disable iff (!ARST_N_IN)
        state_reg == ST_INIT && REQ_VALID_IN && REQ_STATE_IN == REQ_BOOT && !BOOT_SUPPORTED_IN
        |=> state_reg == ST_INIT && ERR_MAIN_OUT == 8'h81 && ERR_SUB_OUT == 4'h3
            && ERR_EVENT_OUT;
    endproperty
    a_boot_unsup: assert property (p_boot_unsup)
        else $error("unsupported boot not refused");

    property p_fw_incompat;
        @(posedge MCLK_IN) disable iff (!ARST_N_IN)
        state_reg == ST_BOOT && FW_INCOMPAT_IN && !REQ_VALID_IN
        |=> ERR_MAIN_OUT == 8'h81 && ERR_SUB_OUT == 4'h4 && state_reg == ST_BOOT;
    endproperty
    a_fw_incompat: assert property (p_fw_incompat)
        else $error("firmware mismatch misreported");

    property p_mbx;
        @(posedge MCLK_IN) disable iff (!ARST_N_IN)
        state_reg == ST_INIT && REQ_VALID_IN && REQ_STATE_IN == REQ_BOOT
            && BOOT_SUPPORTED_IN && !MBX_BOOT_OK_IN
        |=> state_reg == ST_INIT && ERR_MAIN_OUT == 8'h81 && ERR_SUB_OUT == 4'h5;
    endproperty
    a_mbx: assert property (p_mbx) else $error("mailbox boot fault misreported");

    property p_fw_incompat_init;
        @(posedge MCLK_IN) disable iff (!ARST_N_IN)
        state_reg == ST_INIT && FW_INCOMPAT_IN && !REQ_VALID_IN
        |=> ERR_MAIN_OUT == 8'h81 && ERR_SUB_OUT == 4'h4 && state_reg == ST_INIT;
    endproperty
    a_fw_incompat_init: assert property (p_fw_incompat_init)
        else $error("firmware mismatch in init misreported");

    property p_unknown_op;
        @(posedge MCLK_IN) disable iff (!ARST_N_IN)
        state_reg == ST_OP && REQ_VALID_IN && !req_known
        |=> state_reg == ST_SAFEOP && ERR_MAIN_OUT == 8'h81 && ERR_SUB_OUT == 4'h2;
    endproperty
    a_unknown_op: assert property (p_unknown_op)
        else $error("unknown request from op handled wrong");

    property p_event;
        @(posedge MCLK_IN) disable iff (!ARST_N_IN)
        err_any |=> ERR_EVENT_OUT && ERR_ACTIVE_OUT && DISP_OUT[39:24] == {CHR_E, CHR_R};
    endproperty
    a_event: assert property (p_event)
        else $error("fault not latched");

endmodule

`default_nettype wire

// [fbse_master_model.sv]
// master model: issues transition requests and memory accesses
// assumes the device samples its inputs on the rising clock edge
`timescale 1ns/1ps
`default_nettype none

module fbse_master_model (
    input wire logic clk_in,
    output logic req_valid_out,
    output logic [3:0] req_state_out,
    output logic mem_req_out,
    output logic [15:0] mem_addr_out
);
    initial begin
        req_valid_out = 1'b0;
        req_state_out = 4'h0;
        mem_req_out = 1'b0;
        mem_addr_out = 16'h0000;
    end

    // ==========
    // requests
    // only what the bench commands is sent; released lines show the inverse
    task automatic req(input logic [3:0] st);
        @(posedge clk_in);
        req_valid_out <= 1'b1;
        req_state_out <= st;
        @(posedge clk_in);
        req_valid_out <= 1'b0;
        req_state_out <= ~st;
    endtask

    task automatic access(input logic [15:0] a);
        @(posedge clk_in);
        mem_req_out <= 1'b1;
        mem_addr_out <= a;
        @(posedge clk_in);
        mem_req_out <= 1'b0;
        mem_addr_out <= ~a;
    endtask
endmodule

`default_nettype wire

// [fieldbus_state_error_handler_test.sv]
// testbench of the fieldbus state error handler
// assumes the master model drives requests and memory accesses
`timescale 1ns/1ps
`default_nettype none

module fieldbus_state_error_handler_test;
    import fbse_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] flt = 3'h0;
    logic bs = 1'b0;
    logic mo = 1'b0;
    logic clr = 1'b0;
    logic rv, mr, evt, act;
    logic [3:0] rs, sb;
    logic [15:0] ma;
    logic [2:0] st;
    logic [7:0] mn;
    logic [39:0] dsp;
    logic [2:0] es = 3'h0;
    logic [7:0] em = 8'h00;
    logic [3:0] eb = 4'h0;
    logic ea = 1'b0;
    logic ee = 1'b0;
    logic [3:0] tbl [5] = '{REQ_INIT, REQ_PREOP, REQ_BOOT, REQ_SAFEOP, REQ_OP};
    int bad_count = 0;
    int cmp_count = 0;

    always #5 mclk = ~mclk;

    fbse_master_model u_fbse_master_model (
        .clk_in(mclk),
        .req_valid_out(rv),
        .req_state_out(rs),
        .mem_req_out(mr),
        .mem_addr_out(ma)
    );

    fbse_handler u_fbse_handler (
        .MCLK_IN(mclk),
        .ARST_N_IN(arst_n),
        .REQ_VALID_IN(rv),
        .REQ_STATE_IN(rs),
        .MEM_REQ_IN(mr),
        .MEM_ADDR_IN(ma),
        .FW_WRITE_FAIL_IN(flt[0]),
        .DESC_MISMATCH_IN(flt[1]),
        .FW_INCOMPAT_IN(flt[2]),
        .BOOT_SUPPORTED_IN(bs),
        .MBX_BOOT_OK_IN(mo),
        .ERR_CLEAR_IN(clr),
        .STATE_OUT(st),
        .ERR_EVENT_OUT(evt),
        .ERR_ACTIVE_OUT(act),
        .ERR_MAIN_OUT(mn),
        .ERR_SUB_OUT(sb),
        .DISP_OUT(dsp)
    );

    // ==========
    // expectations
    function automatic logic [7:0] hexc(input logic [3:0] n);
        return (n < 4'ha) ? CHR_DIGIT0 + 8'(n) : CHR_LETTER_A + 8'(n) - 8'h0a;
    endfunction

    // bit 3 high when the code names a state
    function automatic logic [3:0] tgt(input logic [3:0] c);
        case (c)
            REQ_INIT: return {1'b1, ST_INIT};
            REQ_PREOP: return {1'b1, ST_PREOP};
            REQ_BOOT: return {1'b1, ST_BOOT};
            REQ_SAFEOP: return {1'b1, ST_SAFEOP};
            REQ_OP: return {1'b1, ST_OP};
            default: return 4'h0;
        endcase
    endfunction

    function automatic logic legal(input logic [2:0] s, input logic [2:0] t);
        case (s)
            ST_INIT: return t == ST_PREOP || t == ST_BOOT;
            ST_PREOP: return t == ST_INIT || t == ST_SAFEOP;
            ST_BOOT: return t == ST_INIT;
            default: return t != ST_BOOT;
        endcase
    endfunction

    // ==========
    // compares
    task automatic chk_state(input logic [2:0] g, input logic [2:0] x);
        cmp_count++;
        if (g !== x) begin
            bad_count++;
            $display("unexpected state at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    task automatic chk_err(input logic [53:0] g, input logic [53:0] x);
        cmp_count++;
        if (g !== x) begin
            bad_count++;
            $display("unexpected error at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    task automatic check;
        logic [39:0] d;
        d = ea ? {CHR_E, CHR_R, hexc(em[7:4]), hexc(em[3:0]), hexc(eb)} : DISP_RESET;
        chk_state(st, es);
        chk_err({evt, act, mn, sb, d}, {ee, ea, em, eb, d});
        chk_err({40'h0, dsp}, {40'h0, d});
    endtask

    task automatic set_err(input logic [7:0] m, input logic [3:0] b);
        ee = 1'b1;
        ea = 1'b1;
        em = m;
        eb = b;
    endtask

    // ==========
    // operations
    task automatic tr(input logic [3:0] c);
        logic [3:0] t;
        logic ib;
        t = tgt(c);
        ib = es == ST_INIT && t[2:0] == ST_BOOT;
        ee = 1'b0;
        u_fbse_master_model.req(c);
        #1;
        if (!t[3]) set_err(MAIN_SM, SUB_UNKNOWN_TR);
        else if (t[2:0] == es) ee = 1'b0;
        else if (ib && !bs) set_err(MAIN_SM, SUB_BOOT_UNSUP);
        else if (ib && !mo) set_err(MAIN_SM, SUB_MBX_BOOT);
        else if (!legal(es, t[2:0])) set_err(MAIN_SM, SUB_ILLEGAL_TR);
        else es = t[2:0];
        if (ee && es == ST_OP) es = ST_SAFEOP;
        check();
    endtask

    task automatic fault(input logic [2:0] f);
        ee = 1'b0;
        @(posedge mclk);
        flt <= f;
        @(posedge mclk);
        flt <= 3'h0;
        #1;
        if (f[2] && (es == ST_INIT || es == ST_BOOT)) set_err(MAIN_SM, SUB_FW_INCOMPAT);
        else if (f[1] && es == ST_INIT) set_err(MAIN_COMM, SUB_DESC_MISMATCH);
        else if (f[0] && es == ST_BOOT) set_err(MAIN_COMM, SUB_FW_WRITE);
        check();
    endtask

    task automatic faults;
        for (int i = 0; i < 3; i++) fault(3'h1 << i);
    endtask

    task automatic mem(input logic [15:0] a);
        ee = 1'b0;
        u_fbse_master_model.access(a);
        #1;
        if (a > MEM_ADDR_LIMIT) set_err(MAIN_COMM, SUB_MEM_RANGE);
        check();
    endtask

    task automatic cfg(input logic b, input logic m);
        @(posedge mclk);
        bs <= b;
        mo <= m;
    endtask

    task automatic clear;
        ee = 1'b0;
        @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        #1;
        ea = 1'b0;
        check();
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        #500000;
        bad_count++;
        wrap_up();
    end

    initial begin
        int r;
        logic [3:0] c;
        r = $urandom(32'h784b);
        repeat (7) @(posedge mclk);
        #1;
        check();
        @(posedge mclk);
        arst_n <= 1'b1;
        $display("test reset done");
        tr(REQ_BOOT);
        cfg(1'b1, 1'b0);
        tr(REQ_BOOT);
        cfg(1'b1, 1'b1);
        tr(REQ_BOOT);
        faults();
        tr(REQ_PREOP);
        tr(REQ_INIT);
        faults();
        tr(REQ_PREOP);
        faults();
        tr(REQ_SAFEOP);
        tr(REQ_OP);
        mem(16'h1000);
        mem(16'h0fff);
        tr(4'h5);
        tr(REQ_OP);
        tr(REQ_BOOT);
        clear();
        $display("test corners done");
        @(posedge mclk);
        arst_n <= 1'b0;
        @(posedge mclk);
        #1;
        es = ST_INIT;
        ee = 1'b0;
        ea = 1'b0;
        em = MAIN_RESET;
        eb = SUB_RESET;
        check();
        @(posedge mclk);
        arst_n <= 1'b1;
        tr(REQ_PREOP);
        tr(REQ_INIT);
        $display("test mid reset done");
        for (int i = 0; i < 300; i++) begin
            c = ($urandom % 2) ? tbl[$urandom % 5] : 4'($urandom);
            cfg(1'($urandom), 1'($urandom));
            tr(c);
            if (i % 4 == 0) mem(16'($urandom));
            if (i % 8 == 0) fault(3'($urandom));
            if (i % 16 == 0) clear();
        end
        $display("test random done");
        wrap_up();
    end
endmodule

`default_nettype wire
